// ==== cts_pkg.sv ====
// shared constants and types of the camera trigger sequencer
package cts_pkg;

  // clock and time base
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int CYCLES_PER_US = CLK_FREQ_HZ / HZ_PER_MHZ;
  localparam int US_CNT_W = 6;
  localparam int TIME_W = 20;
  // free-running frame period in internal mode, microseconds
  localparam int INT_PERIOD_US = 10_000;

  // burst length and divider ratio ranges and reset values
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_MIN = 10'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
  localparam logic [CNT_W-1:0] BURST_RESET = 10'h001;
  localparam logic [CNT_W-1:0] RATIO_RESET = 10'h001;
  localparam logic [CNT_W-1:0] CNT_STEP = 10'h001;

  // the one divider instance that exists
  localparam logic [1:0] CTR_SEL_ONLY = 2'h0;

  // depth of the trigger cache
  localparam logic [1:0] CACHE_DEPTH = 2'h2;
  localparam logic [1:0] PEND_STEP = 2'h1;

  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'h0,
    SRC_LINE0 = 3'h1,
    SRC_LINE2 = 3'h2,
    SRC_COUNTER = 3'h3,
    SRC_ANY = 3'h4
  } cts_source_e;

  typedef enum logic [1:0] {
    ACT_RISE = 2'h0,
    ACT_FALL = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_LOW = 2'h3
  } cts_act_e;

  typedef enum logic [1:0] {
    CEV_OFF = 2'h0,
    CEV_LINE0 = 2'h1,
    CEV_LINE2 = 2'h2
  } cts_cevt_e;

  typedef enum logic [1:0] {
    CRS_OFF = 2'h0,
    CRS_SOFTWARE = 2'h1
  } cts_crst_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DELAY = 4'h2,
    ST_EXPOSE = 4'h4,
    ST_READOUT = 4'h8
  } cts_state_e;

  // live configuration levels
  typedef struct packed {
    logic trigModeOn;
    cts_source_e source;
    cts_act_e activation;
    logic cacheEnable;
    logic line2IsInput;
    logic [TIME_W-1:0] delayUs;
    logic [TIME_W-1:0] exposureUs;
    logic [TIME_W-1:0] debounceUs;
  } cts_cfg_s;

  // setting writes, each strobe a one-cycle pulse
  typedef struct packed {
    logic burstWr;
    logic [CNT_W-1:0] burstData;
    logic ctrSelWr;
    logic [1:0] ctrSelData;
    logic ctrEvtWr;
    logic [1:0] ctrEvtData;
    logic ctrRstWr;
    logic [1:0] ctrRstData;
    logic ratioWr;
    logic [CNT_W-1:0] ratioData;
    logic ctrClear;
  } cts_wr_s;

  // readback of settings and state
  typedef struct packed {
    logic [CNT_W-1:0] burstCount;
    logic [CNT_W-1:0] ratio;
    logic [1:0] ctrSel;
    logic [1:0] ctrEvt;
    logic [1:0] ctrRst;
    logic [CNT_W-1:0] progress;
    logic [1:0] pending;
  } cts_stat_s;

endpackage : cts_pkg

// ==== cts_trigger_sequencer.sv ====
// frame trigger source select, qualify, delay, cache and burst sequencer
`timescale 1ns/10ps
// Operation
// - counter source divides selected input event rate
// - only divider instance zero may be selected
// - divider input line 0 or 2, resets disabled
// - clear source software only; clear needs it
// - divider ratio read/write, 1 to 1023
// - progress shows events counted so far
// - any-source mode takes software, lines, divider
// - activation skips software; debounce lines only
// - frames per trigger accepts 1 to 1023
// - each trigger gives exactly n exposures; internal-mode triggers give one
// - programmable delay before responding to trigger
// - caching off: triggers during burst dropped
// - caching on: hold up to two triggers
// - cached exposure waits for last frame
// - rising edge starts exposure
// - falling edge starts exposure
// - level high holds exposure while high for line triggers taken at idle
// - level low holds exposure while low for line triggers taken at idle
// - external sources ignored unless mode on
// - hardware lines pass programmable debounce
module cts_trigger_sequencer
  import cts_pkg::*;
#(
  parameter int INT_PERIOD_US_P = INT_PERIOD_US
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // trigger pins and software command
  input wire logic line0In,
  input wire logic line2In,
  input wire logic softTrigger,
  // live configuration and setting writes
  input wire cts_cfg_s cfg,
  input wire cts_wr_s wr,
  // sensor readout reports a frame created
  input wire logic frameDone,
  // exposure control
  output logic exposeStart,
  output logic exposing,
  output logic burstActive,
  output logic triggerTaken,
  output logic triggerDropped,
  // readback
  output cts_stat_s stat
);

  localparam logic [US_CNT_W-1:0] US_LAST = US_CNT_W'(CYCLES_PER_US - 1);
  localparam logic [TIME_W-1:0] INT_LAST = TIME_W'(INT_PERIOD_US_P - 1);

  // start of an active phase under the chosen activation
  function automatic logic isActive(input cts_act_e act, input logic lvl);
    isActive = (act == ACT_FALL || act == ACT_LOW) ? ~lvl : lvl;
  endfunction : isActive

  function automatic logic startEdge(input cts_act_e act, input logic prev,
                                     input logic cur);
    startEdge = isActive(act, cur) & ~isActive(act, prev);
  endfunction : startEdge

  // microsecond tick shared by delay, exposure, debounce and period
  logic [US_CNT_W-1:0] usCnt;
  logic usTick;
  wire usWrap = (usCnt == US_LAST);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      usCnt <= '0;
      usTick <= 1'b0;
    end else begin
      usCnt <= usWrap ? '0 : usCnt + 1'b1;
      usTick <= usWrap;
    end
  end

  // per-line synchroniser, debounce and edge detect
  wire [1:0] pinIn = {line2In, line0In};
  logic [1:0] lineSync;
  logic [1:0] lineClean;
  logic [1:0] lineEdge;
  logic [1:0] lineAct;

  genvar g;
  for (g = 0; g < 2; g++) begin : gLine
    logic [2:0] sh;
    logic syncLvl;
    logic cleanLvl;
    logic cleanPrev;
    logic [TIME_W-1:0] stableUs;
    // one tick beyond the setting, since the first tick lands at any phase
    wire debDone = (cfg.debounceUs == '0) || (stableUs > cfg.debounceUs);

    // the first stage feeds only the second; level moves when 2nd and 3rd agree
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        sh <= '0;
        syncLvl <= 1'b0;
      end else begin
        sh <= {sh[1:0], pinIn[g]};
        if (sh[1] == sh[2])
          syncLvl <= sh[2];
      end
    end

    // level must stay changed for the debounce time before it is taken
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        cleanLvl <= 1'b0;
        cleanPrev <= 1'b0;
        stableUs <= '0;
      end else begin
        cleanPrev <= cleanLvl;
        if (syncLvl == cleanLvl)
          stableUs <= '0;
        else if (debDone) begin
          cleanLvl <= syncLvl;
          stableUs <= '0;
        end else if (usTick)
          stableUs <= stableUs + 1'b1;
      end
    end

    assign lineSync[g] = syncLvl;
    assign lineClean[g] = cleanLvl;
    assign lineEdge[g] = startEdge(cfg.activation, cleanPrev, cleanLvl);
    assign lineAct[g] = isActive(cfg.activation, cleanLvl);
  end

  // hardware source lines in use; line 2 only while set as input
  wire srcAny = (cfg.source == SRC_ANY);
  wire useLine0 = (cfg.source == SRC_LINE0) || srcAny;
  wire useLine2 = ((cfg.source == SRC_LINE2) || srcAny) && cfg.line2IsInput;
  wire [1:0] lineUse = {useLine2, useLine0};
  wire hwEvt = |(lineUse & lineEdge);
  wire hwHold = |(lineUse & lineAct);
  wire levelMode = (cfg.activation == ACT_HIGH) || (cfg.activation == ACT_LOW);

  // burst length and divider settings
  logic [CNT_W-1:0] burstCount;
  logic [CNT_W-1:0] ratio;
  logic [1:0] ctrSel;
  cts_cevt_e ctrEvt;
  cts_crst_e ctrRst;

  wire burstOk = (wr.burstData >= CNT_MIN) && (wr.burstData <= CNT_MAX);
  wire ratioOk = (wr.ratioData >= CNT_MIN) && (wr.ratioData <= CNT_MAX);
  wire selOk = (wr.ctrSelData == CTR_SEL_ONLY);
  wire evtOk = (wr.ctrEvtData == CEV_OFF) || (wr.ctrEvtData == CEV_LINE0) ||
               (wr.ctrEvtData == CEV_LINE2);
  wire rstOk = (wr.ctrRstData == CRS_OFF) || (wr.ctrRstData == CRS_SOFTWARE);

  // out-of-range writes are ignored and the old value stays
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      burstCount <= BURST_RESET;
      ratio <= RATIO_RESET;
      ctrSel <= CTR_SEL_ONLY;
      ctrEvt <= CEV_OFF;
      ctrRst <= CRS_OFF;
    end else begin
      if (wr.burstWr && burstOk)
        burstCount <= wr.burstData;
      if (wr.ratioWr && ratioOk)
        ratio <= wr.ratioData;
      if (wr.ctrSelWr && selOk)
        ctrSel <= wr.ctrSelData;
      if (wr.ctrEvtWr && evtOk)
        ctrEvt <= cts_cevt_e'(wr.ctrEvtData);
      if (wr.ctrRstWr && rstOk)
        ctrRst <= cts_crst_e'(wr.ctrRstData);
    end
  end

  // divider counts undebounced synced events on its own line
  logic ctrPrev;
  logic ctrFire;
  logic [CNT_W-1:0] progress;
  wire ctrLvl = (ctrEvt == CEV_LINE0) ? lineSync[0] :
                (ctrEvt == CEV_LINE2) ? lineSync[1] : 1'b0;
  wire ctrEdge = (ctrEvt != CEV_OFF) &&
                 startEdge(cfg.activation, ctrPrev, ctrLvl);
  wire ctrClr = wr.ctrClear && (ctrRst == CRS_SOFTWARE);
  wire [CNT_W-1:0] progNext = progress + CNT_STEP;
  wire ctrHit = ctrEdge && (progNext >= ratio);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrPrev <= 1'b0;
      progress <= '0;
      ctrFire <= 1'b0;
    end else begin
      ctrPrev <= ctrLvl;
      ctrFire <= ctrHit && !ctrClr;
      if (ctrClr || ctrHit)
        progress <= '0;
      else if (ctrEdge)
        progress <= progNext;
    end
  end

  // internal frame timing while external mode is off
  logic [TIME_W-1:0] intCnt;
  logic intFire;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      intCnt <= '0;
      intFire <= 1'b0;
    end else begin
      intFire <= usTick && (intCnt == INT_LAST);
      if (usTick)
        intCnt <= (intCnt == INT_LAST) ? '0 : intCnt + 1'b1;
    end
  end

  // merged trigger request; software skips activation
  wire srcSw = (cfg.source == SRC_SOFTWARE) || srcAny;
  wire srcCtr = (cfg.source == SRC_COUNTER) || srcAny;
  wire extReq = cfg.trigModeOn &&
                ((softTrigger && srcSw) || hwEvt ||
                 (ctrFire && srcCtr));
  wire intReq = !cfg.trigModeOn && intFire;

  // sequencer state
  cts_state_e state;
  cts_state_e next_state;
  logic [TIME_W-1:0] phaseUs;
  logic [CNT_W-1:0] framesDone;
  logic [CNT_W-1:0] burstLen;
  logic [1:0] pending;
  logic byLine;

  wire idle = (state == ST_IDLE);
  wire [TIME_W-1:0] delayLim = cfg.trigModeOn ? cfg.delayUs : '0;
  wire [CNT_W-1:0] framesNext = framesDone + CNT_STEP;
  wire burstMore = framesNext < burstLen;
  wire delayDone = phaseUs >= delayLim;
  wire expoDone = byLine ? !hwHold :
                  (phaseUs >= cfg.exposureUs);
  wire startNew = idle && (extReq || intReq);
  // a trigger while busy is cached or dropped, never restarts the burst
  wire busyReq = !idle && extReq;
  wire cacheIn = busyReq && cfg.cacheEnable;
  wire lastFrame = (state == ST_READOUT) && frameDone && !burstMore;
  // a trigger cached on the last frame runs at once instead of stranding
  wire popCache = lastFrame && ((pending != '0) || cacheIn);
  wire pushCache = cacheIn && ((pending < CACHE_DEPTH) || popCache);
  wire dropReq = busyReq && !pushCache;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (startNew)
          next_state = ST_DELAY;
      end
      ST_DELAY: begin
        if (delayDone)
          next_state = ST_EXPOSE;
      end
      ST_EXPOSE: begin
        if (expoDone)
          next_state = ST_READOUT;
      end
      ST_READOUT: begin
        // the next trigger waits here until the last frame is created
        if (frameDone) begin
          if (burstMore)
            next_state = ST_EXPOSE;
          else if (popCache)
            next_state = ST_DELAY;
          else
            next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  wire enterExpose = (next_state == ST_EXPOSE) && (state != ST_EXPOSE);
  wire phaseClr = (next_state != state);

  // state register and phase timer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      phaseUs <= '0;
    end else begin
      state <= next_state;
      if (phaseClr)
        phaseUs <= '0;
      else if (usTick)
        phaseUs <= phaseUs + 1'b1;
    end
  end

  // burst length latched per trigger so mid-burst writes do not cut it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      framesDone <= '0;
      burstLen <= BURST_RESET;
      byLine <= 1'b0;
    end else if (startNew || popCache) begin
      framesDone <= '0;
      burstLen <= (startNew && intReq) ? CNT_MIN : burstCount;
      byLine <= startNew && hwEvt && levelMode;
    end else if ((state == ST_READOUT) && frameDone)
      framesDone <= framesNext;
  end

  // cache depth; a push in the cycle of a pop is kept
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      pending <= '0;
    else if (pushCache && !popCache)
      pending <= pending + PEND_STEP;
    else if (popCache && !pushCache)
      pending <= pending - PEND_STEP;
  end

  // registered outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      exposeStart <= 1'b0;
      exposing <= 1'b0;
      burstActive <= 1'b0;
      triggerTaken <= 1'b0;
      triggerDropped <= 1'b0;
    end else begin
      exposeStart <= enterExpose;
      exposing <= (next_state == ST_EXPOSE);
      burstActive <= (next_state != ST_IDLE);
      triggerTaken <= startNew || pushCache;
      triggerDropped <= dropReq;
    end
  end

  // readback is wiring of the setting and state flops
  assign stat.burstCount = burstCount;
  assign stat.ratio = ratio;
  assign stat.ctrSel = ctrSel;
  assign stat.ctrEvt = ctrEvt;
  assign stat.ctrRst = ctrRst;
  assign stat.progress = progress;
  assign stat.pending = pending;

endmodule : cts_trigger_sequencer

// ==== cts_trigger_monitor.sv ====
// port-level assertions for the trigger sequencer
`timescale 1ns/10ps
module cts_trigger_monitor
  import cts_pkg::*;
#(
  parameter int INT_PERIOD_US_P = INT_PERIOD_US
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pins, commands and settings
  input wire logic line0In,
  input wire logic line2In,
  input wire logic softTrigger,
  input wire cts_cfg_s cfg,
  input wire cts_wr_s wr,
  input wire logic frameDone,
  // responses
  input wire logic exposeStart,
  input wire logic exposing,
  input wire logic burstActive,
  input wire logic triggerTaken,
  input wire logic triggerDropped,
  input wire cts_stat_s stat
);
  // one domain, so clock and reset are stated once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // legal writes land a cycle later, zero is refused
  burst_wr_a: assert property (wr.burstWr && wr.burstData != '0 |=>
    stat.burstCount == $past(wr.burstData)) else $error("burst write lost");
  ratio_wr_a: assert property (wr.ratioWr && wr.ratioData != '0 |=>
    stat.ratio == $past(wr.ratioData)) else $error("ratio write lost");
  zero_keep_a: assert property (wr.burstWr && wr.burstData == '0 |=>
    $stable(stat.burstCount)) else $error("zero burst taken");
  one_ctr_a: assert property (stat.ctrSel == CTR_SEL_ONLY)
    else $error("second divider selected");
  evt_keep_a: assert property (wr.ctrEvtWr && wr.ctrEvtData == 2'h3 |=>
    $stable(stat.ctrEvt)) else $error("bad event source taken");
  // clear only acts with the software source chosen, and beats an event
  clear_zero_a: assert property (wr.ctrClear && !wr.ctrRstWr &&
    stat.ctrRst == CRS_SOFTWARE |=> stat.progress == '0)
    else $error("clear ignored");
  drop_busy_a: assert property (triggerDropped |->
    $past(burstActive) && $past(cfg.trigModeOn)) else $error("bad drop");
  start_burst_a: assert property (exposeStart |->
    exposing && burstActive) else $error("exposure outside burst");
  delay_start_a: assert property ($rose(burstActive) &&
    !cfg.cacheEnable && cfg.trigModeOn |=> exposeStart == (cfg.delayUs == '0))
    else $error("delay not kept");
  pend_depth_a: assert property (stat.pending <= CACHE_DEPTH)
    else $error("cache too deep");
  taken_busy_a: assert property (triggerTaken |-> burstActive)
    else $error("trigger taken outside burst");

  // main scenarios reached
  cover property (triggerDropped);
  cover property (stat.pending == CACHE_DEPTH);
  cover property (exposeStart && cfg.activation == ACT_LOW);
endmodule : cts_trigger_monitor

bind cts_trigger_sequencer cts_trigger_monitor #(
  .INT_PERIOD_US_P(INT_PERIOD_US_P)
) u_monitor (
  .sys_clk(sys_clk), .reset_n(reset_n), .line0In(line0In),
  .line2In(line2In), .softTrigger(softTrigger), .cfg(cfg), .wr(wr),
  .frameDone(frameDone), .exposeStart(exposeStart), .exposing(exposing),
  .burstActive(burstActive), .triggerTaken(triggerTaken),
  .triggerDropped(triggerDropped), .stat(stat));

// ==== cts_readout_model.sv ====
// readout model: one frame pulse a set time after each exposure
`timescale 1ns/10ps
module cts_readout_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // exposure seen, readout time, frame created
  input wire logic exposing,
  input wire logic [7:0] latency,
  output logic frameDone
);
  logic wasExp;
  logic [8:0] left;

  // a slow readout makes cached triggers queue behind it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wasExp <= 1'h0;
      left <= 9'h000;
      frameDone <= 1'h0;
    end else begin
      wasExp <= exposing;
      frameDone <= (left == 9'h001);
      if (wasExp && !exposing) left <= {1'h0, latency};
      else if (left != 9'h000) left <= left - 9'h001;
    end
  end
endmodule : cts_readout_model

// ==== cts_trigger_sequencer_test.sv ====
// self-checking bench for the trigger sequencer
`timescale 1ns/10ps
module cts_trigger_sequencer_test
  import cts_pkg::*;
;
  logic sys_clk, reset_n, line0In, line2In, softTrigger, frameDone;
  logic exposeStart, exposing, burstActive, triggerTaken, triggerDropped;
  logic [7:0] latency;
  logic [9:0] d, keep;
  cts_cfg_s cfg;
  cts_wr_s wr;
  cts_stat_s stat;
  cts_act_e act;
  int err_total = 0, checks_done = 0, startCnt = 0, dropCnt = 0;
  int earlyCnt = 0, takeCnt = 0, s0, d0, t0, i;
  integer seed = 32'h0000_422e;
  bit owe, wasExp;

  cts_trigger_sequencer #(.INT_PERIOD_US_P(50)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .line0In(line0In),
    .line2In(line2In), .softTrigger(softTrigger), .cfg(cfg), .wr(wr),
    .frameDone(frameDone), .exposeStart(exposeStart), .exposing(exposing),
    .burstActive(burstActive), .triggerTaken(triggerTaken),
    .triggerDropped(triggerDropped), .stat(stat));
  cts_readout_model u_readout (.sys_clk(sys_clk), .reset_n(reset_n),
    .exposing(exposing), .latency(latency), .frameDone(frameDone));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // tally starts, drops and exposures begun before the prior frame exists
  always @(posedge sys_clk) begin
    if (exposeStart === 1'h1) startCnt++;
    if (exposeStart === 1'h1 && owe) earlyCnt++;
    if (triggerDropped === 1'h1) dropCnt++;
    if (triggerTaken === 1'h1) takeCnt++;
    if (frameDone === 1'h1) owe = 1'h0;
    else if (wasExp && exposing === 1'h0) owe = 1'h1;
    wasExp = (exposing === 1'h1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic chk(input string what, input logic [9:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one write strobe, then look once the readback has moved
  task automatic put(input cts_wr_s w);
    tick(1);
    wr <= w;
    tick(1);
    wr <= '0;
    tick(1);
    #1;
  endtask : put

  task automatic fire();
    tick(1);
    softTrigger <= 1'h1;
    tick(1);
    softTrigger <= 1'h0;
  endtask : fire

  // wait until no burst runs and nothing is cached
  task automatic settle();
    for (int k = 0; k < 5000; k++) begin
      tick(1);
      if (k > 300 && burstActive === 1'h0 && stat.pending === 2'h0) break;
    end
    #1;
  endtask : settle

  // divider event pulse on the bidirectional line
  task automatic pulse2();
    tick(1);
    line2In <= 1'h1;
    tick(10);
    line2In <= 1'h0;
    tick(12);
    #1;
  endtask : pulse2

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // cut a hang short
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    $display("MISMATCH watchdog expected end seen hang");
    finish_test();
  end

  // main sequence
  initial begin
    sys_clk = 1'h0;
    reset_n = 1'h0;
    line0In = 1'h0;
    line2In = 1'h0;
    softTrigger = 1'h0;
    wr = '0;
    cfg = '0;
    cfg.trigModeOn = 1'h1;
    cfg.exposureUs = 20'h0_0001;
    cfg.debounceUs = 20'h0_0001;
    cfg.delayUs = 20'h0_0002;
    latency = 8'h10;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'h1;
    tick(1);
    #1;
    chk("burstCount", 10'h001, stat.burstCount);
    chk("ratio", 10'h001, stat.ratio);
    chk("ctrEvt", 10'h000, 10'(stat.ctrEvt));
    chk("ctrRst", 10'h000, 10'(stat.ctrRst));
    $display("reset test done");
    keep = 10'h001;
    for (i = 0; i < 12; i++) begin
      d = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($random(seed));
      if (d != 10'h000) keep = d;
      put('{burstWr: 1'h1, burstData: d, default: '0});
      chk("burstCount", keep, stat.burstCount);
      put('{ratioWr: 1'h1, ratioData: d, default: '0});
      chk("ratio", keep, stat.ratio);
    end
    put('{ctrSelWr: 1'h1, ctrSelData: 2'h1, default: '0});
    chk("ctrSel", 10'h000, 10'(stat.ctrSel));
    put('{ctrRstWr: 1'h1, ctrRstData: 2'h2, default: '0});
    chk("ctrRst", 10'h000, 10'(stat.ctrRst));
    $display("settings test done");
    put('{burstWr: 1'h1, burstData: 10'h003, default: '0});
    s0 = startCnt;
    fire();
    settle();
    chk("frames", 10'h003, 10'(startCnt - s0));
    s0 = startCnt;
    d0 = dropCnt;
    fire();
    tick(5);
    fire();
    settle();
    chk("frames", 10'h003, 10'(startCnt - s0));
    chk("drops", 10'h001, 10'(dropCnt - d0));
    $display("burst test done");
    // slow readout and no delay so cached triggers must wait
    cfg.cacheEnable <= 1'h1;
    cfg.delayUs <= 20'h0_0000;
    latency <= 8'hC8;
    put('{burstWr: 1'h1, burstData: 10'h001, default: '0});
    s0 = startCnt;
    d0 = dropCnt;
    t0 = takeCnt;
    repeat (4) fire();
    settle();
    chk("frames", 10'h003, 10'(startCnt - s0));
    chk("taken", 10'h003, 10'(takeCnt - t0));
    chk("drops", 10'h001, 10'(dropCnt - d0));
    chk("early", 10'h000, 10'(earlyCnt));
    $display("cache test done");
    cfg.cacheEnable <= 1'h0;
    latency <= 8'h10;
    for (i = 0; i < 5; i++) begin
      act = cts_act_e'(i % 4);
      tick(1);
      cfg.activation <= act;
      cfg.source <= (i == 4) ? SRC_LINE2 : SRC_LINE0;
      cfg.line2IsInput <= 1'h1;
      line0In <= act[0];
      line2In <= act[0];
      tick(200);
      s0 = startCnt;
      line0In <= (i == 4) ? act[0] : !act[0];
      line2In <= !act[0];
      tick(10);
      line0In <= act[0];
      line2In <= act[0];
      tick(100);
      #1;
      chk("glitch", 10'h000, 10'(startCnt - s0));
      tick(1);
      line0In <= (i == 4) ? act[0] : !act[0];
      line2In <= !act[0];
      tick(220);
      #1;
      chk("exposing", 10'(act[1]), 10'(exposing));
      tick(1);
      line0In <= act[0];
      line2In <= act[0];
      settle();
      chk("frames", 10'h001, 10'(startCnt - s0));
    end
    $display("line test done");
    cfg.source <= SRC_COUNTER;
    cfg.activation <= ACT_RISE;
    put('{ctrEvtWr: 1'h1, ctrEvtData: CEV_LINE2, default: '0});
    put('{ratioWr: 1'h1, ratioData: 10'h003, default: '0});
    s0 = startCnt;
    for (i = 1; i < 5; i++) begin
      pulse2();
      chk("progress", 10'(i % 3), stat.progress);
    end
    put('{ctrClear: 1'h1, default: '0});
    chk("progress", 10'h001, stat.progress);
    put('{ctrRstWr: 1'h1, ctrRstData: CRS_SOFTWARE, default: '0});
    put('{ctrClear: 1'h1, default: '0});
    chk("progress", 10'h000, stat.progress);
    settle();
    chk("frames", 10'h001, 10'(startCnt - s0));
    $display("divider test done");
    cfg.source <= SRC_ANY;
    cfg.activation <= ACT_FALL;
    s0 = startCnt;
    fire();
    settle();
    chk("frames", 10'h001, 10'(startCnt - s0));
    put('{burstWr: 1'h1, burstData: 10'h003, default: '0});
    cfg.trigModeOn <= 1'h0;
    fire();
    // align to one internal exposure, then a window of two periods
    s0 = startCnt;
    for (i = 0; i < 2100 && startCnt == s0; i++) begin
      tick(1);
      #1;
    end
    s0 = startCnt;
    tick(4010);
    #1;
    chk("frames", 10'h002, 10'(startCnt - s0));
    $display("mode test done");
    finish_test();
  end
endmodule : cts_trigger_sequencer_test
